// [core/ba_exec_core.sv]
// Functional notes
// - Any program counter write clears its ninth bit, except the jump.
// - Port operands read pin levels, not output latch values.
// - Direction load with 5 or 6 copies accumulator to port direction latches.
// - Timer count target with d=1 clears prescaler when assigned there.
// - Add accumulator to file, sets carry, nibble carry, zero; one cycle.
// - Select 0 writes the accumulator, select 1 the file register.
// - AND accumulator with file, routed by select, zero flag only.
// - AND with literal writes accumulator and updates zero flag.
// - Instruction cycle is four clocks; PC changes cost two cycles.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module ba_exec_core
    import ba_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Instruction fetch
    input  wire logic [11:0] instr_word,
    output logic      [8:0]  fetch_pc_q,
    output logic             fetch_flush_q,
    // Data file register space
    output logic      [4:0]  file_addr_q,
    input  wire logic [7:0]  file_rdata,
    output logic      [7:0]  file_wdata_q,
    output logic             file_we_q,
    input  wire logic [7:0]  first_io_port_pins,
    input  wire logic [7:0]  second_io_port_pins,
    output logic      [7:0]  first_port_dir_q,
    output logic      [7:0]  second_port_dir_q,
    output logic             presc_clear_q,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    logic [1:0]  phase_q;
    logic [11:0] ir_q;
    logic [7:0]  acc_q;
    logic        carry_q;
    logic        nib_carry_q;
    logic        zero_q;
    logic [1:0]  ctrl_q;
    logic [3:0]  awaddr_q;
    logic        aw_full_q;
    logic        w_full_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    // Instruction cycle divider
    wire run        = ctrl_q[CTRL_RUN_BIT];
    wire presc_tmr  = ctrl_q[CTRL_PRESC_BIT];
    wire fetch_en   = run && (phase_q == PHASE_FETCH);
    wire exec_en    = run && (phase_q == PHASE_EXEC) && !fetch_flush_q;

    // Decode
    // five-bit address
    wire [4:0] f_addr   = ir_q[4:0];
    wire       dest_f   = ir_q[DEST_BIT];
    wire is_add  = (ir_q[11:6] == OP_ADD_ACC_TO_FILE);
    wire is_andf = (ir_q[11:6] == OP_AND_ACC_WITH_FILE);
    wire is_andl = (ir_q[11:8] == OP_AND_ACC_WITH_LIT);
    wire is_jump = (ir_q[11:9] == OP_UNCOND_JUMP);
    wire is_dir  = (ir_q[11:3] == OP_LOAD_PIN_DIR);
    wire is_file = is_add || is_andf;
    wire to_file = is_file && dest_f;
    wire pcl_wr  = to_file && (f_addr == FILE_PC_LOW);

    wire [7:0] file_val = (f_addr == FILE_FIRST_PORT)  ? first_io_port_pins :
                          (f_addr == FILE_SECOND_PORT) ? second_io_port_pins :
                          file_rdata;
    wire [7:0] operand  = is_andl ? ir_q[7:0] : file_val;

    logic [7:0] alu_res;
    logic       alu_c;
    logic       alu_dc;
    logic       alu_z;

    ba_alu ba_alu_i (
        .acc       (acc_q),
        .operand   (operand),
        .do_add    (is_add),
        .result    (alu_res),
        .carry     (alu_c),
        .nib_carry (alu_dc),
        .zero      (alu_z)
    );

    // Phase counter and instruction capture
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_q     <= PHASE_FETCH;
            ir_q        <= 12'h000;
            file_addr_q <= 5'h00;
        end
        else if (run)
        begin
            phase_q <= phase_q + 2'h1;
            if (fetch_en)
            begin
                ir_q        <= instr_word;
                file_addr_q <= instr_word[4:0];
            end
        end
    end

    // Program counter and discard of the prefetched word
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fetch_pc_q    <= PC_RESET;
            fetch_flush_q <= 1'b0;
        end
        else if (run && phase_q == PHASE_EXEC)
        begin
            // flush cycle holds PC so target is refetched
            fetch_flush_q <= exec_en && (is_jump || pcl_wr);
            if (exec_en && is_jump)
                fetch_pc_q <= ir_q[8:0];
            else if (exec_en && pcl_wr)
                fetch_pc_q <= {1'b0, alu_res};
            else if (!fetch_flush_q)
                fetch_pc_q <= fetch_pc_q + 9'h001;
        end
    end

    // Accumulator, flags and file write-back
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_q        <= ACC_RESET;
            carry_q      <= 1'b0;
            nib_carry_q  <= 1'b0;
            zero_q       <= 1'b0;
            file_we_q    <= 1'b0;
            file_wdata_q <= 8'h00;
        end
        else
        begin
            file_we_q <= exec_en && to_file;
            if (exec_en && to_file)
                file_wdata_q <= alu_res;
            if (exec_en && (is_andl || (is_file && !dest_f)))
                acc_q <= alu_res;
            if (exec_en && is_add)
            begin
                carry_q     <= alu_c;
                nib_carry_q <= alu_dc;
            end
            if (exec_en && (is_file || is_andl))
                zero_q <= alu_z;
        end
    end

    // Direction latches and prescaler clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            first_port_dir_q  <= DIR_RESET;
            second_port_dir_q <= DIR_RESET;
            presc_clear_q     <= 1'b0;
        end
        else
        begin
            if (exec_en && is_dir && ir_q[2:0] == FILE_FIRST_PORT[2:0])
                first_port_dir_q <= acc_q;
            if (exec_en && is_dir && ir_q[2:0] == FILE_SECOND_PORT[2:0])
                second_port_dir_q <= acc_q;
            presc_clear_q <= exec_en && to_file && presc_tmr
                             && (f_addr == FILE_TIMER_COUNT);
        end
    end

    // AXI4-Lite write side
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs  = s_axi_wvalid && s_axi_wready;
    wire b_hs  = s_axi_bvalid && s_axi_bready;
    wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
    wire wr_ctrl = (awaddr_q == ADDR_CTRL);
    wire wr_ok   = wr_ctrl || (awaddr_q == ADDR_STATUS)
                   || (awaddr_q == ADDR_DIR);
    wire aw_full_d = (aw_full_q || aw_hs) && !b_hs;
    wire w_full_d  = (w_full_q || w_hs) && !b_hs;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            ctrl_q        <= CTRL_RESET;
        end
        else
        begin
            aw_full_q     <= aw_full_d;
            w_full_q      <= w_full_d;
            s_axi_awready <= !aw_full_d;
            s_axi_wready  <= !w_full_d;
            if (aw_hs)
                awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
            if (w_hs)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl && wstrb_q[0])
                    ctrl_q <= wdata_q[1:0];
            end
            else if (b_hs)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read side
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire r_hs  = s_axi_rvalid && s_axi_rready;
    wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
    wire [31:0] stat_word = (32'(acc_q) << STAT_ACC_LSB)
                          | (32'(carry_q) << STAT_CARRY_BIT)
                          | (32'(nib_carry_q) << STAT_NIB_BIT)
                          | (32'(zero_q) << STAT_ZERO_BIT)
                          | (32'(fetch_pc_q) << STAT_PC_LSB);
    wire [31:0] dir_word = 32'(first_port_dir_q)
                         | (32'(second_port_dir_q) << DIR_SECOND_LSB);
    wire rd_ok = (rd_addr == ADDR_CTRL) || (rd_addr == ADDR_STATUS)
                 || (rd_addr == ADDR_DIR);
    wire [31:0] rd_word = (rd_addr == ADDR_CTRL)   ? 32'(ctrl_q) :
                          (rd_addr == ADDR_STATUS) ? stat_word :
                          (rd_addr == ADDR_DIR)    ? dir_word :
                          32'h0000_0000;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (ar_hs)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r_hs)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule // ba_exec_core

// [core/ba_pkg.sv]
package ba_pkg;

    // Core timing: one instruction cycle spans four oscillator periods
    localparam int unsigned CLOCK_HZ       = 20_000_000;
    localparam int unsigned OSC_PER_CYCLE  = 4;
    localparam logic [1:0]  PHASE_FETCH    = 2'h0;
    localparam logic [1:0]  PHASE_EXEC     = 2'(OSC_PER_CYCLE - 1);

    // Opcode fields of the 12-bit instruction word
    localparam logic [5:0]  OP_ADD_ACC_TO_FILE   = 6'h07;
    localparam logic [5:0]  OP_AND_ACC_WITH_FILE = 6'h05;
    localparam logic [3:0]  OP_AND_ACC_WITH_LIT  = 4'he;
    localparam logic [2:0]  OP_UNCOND_JUMP       = 3'h5;
    localparam logic [8:0]  OP_LOAD_PIN_DIR      = 9'h000;
    localparam int unsigned DEST_BIT             = 5;

    // File register addresses with side effects
    localparam logic [4:0]  FILE_TIMER_COUNT = 5'h01;
    localparam logic [4:0]  FILE_PC_LOW      = 5'h02;
    localparam logic [4:0]  FILE_FIRST_PORT  = 5'h05;
    localparam logic [4:0]  FILE_SECOND_PORT = 5'h06;

    // Reset values
    localparam logic [7:0]  DIR_RESET  = 8'hff;
    localparam logic [8:0]  PC_RESET   = 9'h1ff;
    localparam logic [7:0]  ACC_RESET  = 8'h00;

    // AXI4-Lite register map (byte addresses)
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h4;
    localparam logic [3:0]  ADDR_DIR    = 4'h8;

    // Control register fields
    localparam int unsigned CTRL_RUN_BIT     = 0;
    localparam int unsigned CTRL_PRESC_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET       = 2'h0;

    // Status and direction register fields
    localparam int unsigned STAT_ACC_LSB   = 0;
    localparam int unsigned STAT_CARRY_BIT = 8;
    localparam int unsigned STAT_NIB_BIT   = 9;
    localparam int unsigned STAT_ZERO_BIT  = 10;
    localparam int unsigned STAT_PC_LSB    = 12;
    localparam int unsigned DIR_SECOND_LSB = 8;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// [core/ba_alu.sv]
`timescale 1ns/10ps
module ba_alu
    import ba_pkg::*;
(
    input  wire logic [7:0] acc,
    input  wire logic [7:0] operand,
    input  wire logic       do_add,
    output logic      [7:0] result,
    output logic            carry,
    output logic            nib_carry,
    output logic            zero
);

    wire [8:0] sum_full = {1'b0, acc} + {1'b0, operand};
    wire [4:0] sum_low  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};

    assign result    = do_add ? sum_full[7:0] : (acc & operand);
    assign carry     = sum_full[8];
    assign nib_carry = sum_low[4];
    assign zero      = (result == 8'h00);

endmodule // ba_alu

// [tb/ba_fetch_model.sv]
`timescale 1ns/10ps
module ba_fetch_model
(
    input  wire logic        clock,
    input  wire logic [8:0]  fetch_pc_q,
    input  wire logic [4:0]  file_addr_q,
    input  wire logic [7:0]  file_wdata_q,
    input  wire logic        file_we_q,
    output logic      [11:0] instr_word,
    output logic      [7:0]  file_rdata
);
    logic [11:0] prog [512];
    logic [7:0]  mem  [32];

    // Combinational, so data settle long before the sampling edges
    assign instr_word = prog[fetch_pc_q];
    assign file_rdata = mem[file_addr_q];

    always @(posedge clock)
        if (file_we_q)
            mem[file_addr_q] <= file_wdata_q;
endmodule // ba_fetch_model

// [tb/ba_exec_core_asserts.sv]
`timescale 1ns/10ps
module ba_exec_core_asserts
    import ba_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic [8:0] fetch_pc_q,
    input wire logic       fetch_flush_q,
    input wire logic [4:0] file_addr_q,
    input wire logic       file_we_q,
    input wire logic [7:0] first_port_dir_q,
    input wire logic       presc_clear_q,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_awready
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    property p_we_gap;
        file_we_q |=> !file_we_q [*3];
    endproperty
    a_we_gap: assert property (p_we_gap)
        else $error("file writes too close");
    property p_pc_step;
        $changed(fetch_pc_q) |=> $stable(fetch_pc_q) [*3];
    endproperty
    a_pc_step: assert property (p_pc_step)
        else $error("pc moved inside a cycle");
    property p_flush_len;
        $rose(fetch_flush_q) |-> fetch_flush_q [*4] ##1 !fetch_flush_q;
    endproperty
    a_flush_len: assert property (p_flush_len)
        else $error("flush length wrong");
    property p_pc_low;
        file_we_q && file_addr_q == FILE_PC_LOW
            |-> fetch_flush_q && !fetch_pc_q[8];
    endproperty
    a_pc_low: assert property (p_pc_low)
        else $error("pc low write kept bit 8");
    property p_dir_exec;
        $changed(first_port_dir_q) |-> $changed(fetch_pc_q);
    endproperty
    a_dir_exec: assert property (p_dir_exec)
        else $error("direction changed off exec edge");
    property p_presc;
        presc_clear_q |-> file_we_q && file_addr_q == FILE_TIMER_COUNT;
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler clear without timer write");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read answer late");
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
    endproperty
    a_bdone: assert property (p_bdone)
        else $error("write response not closed");

    c_presc: cover property (presc_clear_q);
    c_jump: cover property (fetch_flush_q && fetch_pc_q[8]);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // ba_exec_core_asserts

bind ba_exec_core ba_exec_core_asserts ba_exec_core_asserts_i (
    .clock            (clock),
    .rst_b            (rst_b),
    .fetch_pc_q       (fetch_pc_q),
    .fetch_flush_q    (fetch_flush_q),
    .file_addr_q      (file_addr_q),
    .file_we_q        (file_we_q),
    .first_port_dir_q (first_port_dir_q),
    .presc_clear_q    (presc_clear_q),
    .s_axi_arvalid    (s_axi_arvalid),
    .s_axi_arready    (s_axi_arready),
    .s_axi_rvalid     (s_axi_rvalid),
    .s_axi_bvalid     (s_axi_bvalid),
    .s_axi_bready     (s_axi_bready),
    .s_axi_awready    (s_axi_awready)
);

// [tb/ba_exec_core_bench.sv]
`timescale 1ns/10ps
module ba_exec_core_bench
    import ba_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] instr_word;
    logic [8:0]  fetch_pc_q;
    logic [7:0]  file_rdata, file_wdata_q, first_port_dir_q, second_port_dir_q;
    logic [7:0]  first_io_port_pins = 8'h10;
    logic [7:0]  second_io_port_pins = 8'h00;
    logic [4:0]  file_addr_q;
    logic        fetch_flush_q, file_we_q, presc_clear_q;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    int          n_fail = 0, compares = 0, n_presc = 0;
    // Program from reset vector 0x1ff on, wrapping to 0x000
    logic [11:0] pgm [11] = '{12'h1d0, 12'h1f1, 12'h172, 12'h153, 12'he05,
        12'h005, 12'he04, 12'h006, 12'h1c5, 12'h1e1, 12'h162};
    logic [4:0]  f_adr [7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h05, 5'h01, 5'h02};
    logic [7:0]  f_ini [7] = '{8'h17, 8'he9, 8'hc2, 8'h0f, 8'haa, 8'hec, 8'h3c};
    logic [7:0]  f_exp [7] = '{8'h17, 8'h00, 8'h02, 8'h0f, 8'haa, 8'h00, 8'h14};

    ba_exec_core ba_exec_core_i (
        .clock               (clock),
        .rst_b               (rst_b),
        .instr_word          (instr_word),
        .fetch_pc_q          (fetch_pc_q),
        .fetch_flush_q       (fetch_flush_q),
        .file_addr_q         (file_addr_q),
        .file_rdata          (file_rdata),
        .file_wdata_q        (file_wdata_q),
        .file_we_q           (file_we_q),
        .first_io_port_pins  (first_io_port_pins),
        .second_io_port_pins (second_io_port_pins),
        .first_port_dir_q    (first_port_dir_q),
        .second_port_dir_q   (second_port_dir_q),
        .presc_clear_q       (presc_clear_q),
        .s_axi_awaddr        (s_axi_awaddr),
        .s_axi_awvalid       (s_axi_awvalid),
        .s_axi_awready       (s_axi_awready),
        .s_axi_wdata         (s_axi_wdata),
        .s_axi_wstrb         (s_axi_wstrb),
        .s_axi_wvalid        (s_axi_wvalid),
        .s_axi_wready        (s_axi_wready),
        .s_axi_bresp         (s_axi_bresp),
        .s_axi_bvalid        (s_axi_bvalid),
        .s_axi_bready        (s_axi_bready),
        .s_axi_araddr        (s_axi_araddr),
        .s_axi_arvalid       (s_axi_arvalid),
        .s_axi_arready       (s_axi_arready),
        .s_axi_rdata         (s_axi_rdata),
        .s_axi_rresp         (s_axi_rresp),
        .s_axi_rvalid        (s_axi_rvalid),
        .s_axi_rready        (s_axi_rready)
    );
    ba_fetch_model ba_fetch_model_i (
        .clock        (clock),
        .fetch_pc_q   (fetch_pc_q),
        .file_addr_q  (file_addr_q),
        .file_wdata_q (file_wdata_q),
        .file_we_q    (file_we_q),
        .instr_word   (instr_word),
        .file_rdata   (file_rdata)
    );

    always #25 clock = ~clock;

    always @(posedge clock)
        if (presc_clear_q === 1'b1)
            n_presc++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(r));
    endtask

    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata & m, e);
        chk(32'(s_axi_rresp), 32'(r));
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (4000) @(posedge clock);
        n_fail++;
        tally_and_finish;
    end

    initial
    begin
        for (int i = 0; i < 512; i++)
            ba_fetch_model_i.prog[i] = 12'heff;
        for (int i = 0; i < 11; i++)
            ba_fetch_model_i.prog[9'(9'h1ff + i)] = pgm[i];
        // Jump target has bit 8 set; both slots cover either flush reading
        ba_fetch_model_i.prog[9'h014] = 12'hbf0;
        ba_fetch_model_i.prog[9'h015] = 12'hbf0;
        for (int i = 0; i < 32; i++)
            ba_fetch_model_i.mem[i] = 8'h00;
        for (int i = 0; i < 7; i++)
            ba_fetch_model_i.mem[f_adr[i]] = f_ini[i];
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        axi_rd(ADDR_STATUS, 32'h001ff0ff, 32'h001ff000, RESP_OKAY);
        axi_rd(ADDR_DIR, 32'hffffffff, 32'h0000ffff, RESP_OKAY);
        axi_rd(4'hc, 32'hffffffff, 32'h0, RESP_SLVERR);
        axi_wr(4'hc, 32'h3, RESP_SLVERR);
        axi_wr(ADDR_STATUS, 32'h3, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
        axi_wr(ADDR_CTRL, 32'h3, RESP_OKAY);
        repeat (80) @(posedge clock);
        axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        axi_rd(ADDR_STATUS, 32'h001007ff, 32'h00100314, RESP_OKAY);
        axi_rd(ADDR_DIR, 32'hffff, 32'h0405, RESP_OKAY);
        chk(32'(first_port_dir_q), 32'h05);
        chk(32'(second_port_dir_q), 32'h04);
        chk(32'(n_presc), 32'h1);
        for (int i = 0; i < 7; i++)
            chk(32'(ba_fetch_model_i.mem[f_adr[i]]), 32'(f_exp[i]));
        tally_and_finish;
    end
endmodule // ba_exec_core_bench
